// *** sdfb_frame_builder.v ***
`timescale 1ns/10ps
`default_nettype none
`include "sdfb_defines.vh"
// Builds and shifts out one data frame per start request.
// Line coding, check computation and range tables live outside this block.
module sdfb_frame_builder
#(
  parameter BIT_DIV = 100
)
(
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire       frameStart,
  input  wire [1:0] startBits,
  input  wire       check_type_select,
  input  wire       state_vector_disable,
  input  wire       data_width_select,
  input  wire       autozero_enable,
  input  wire       phase2Mode0,
  input  wire       runTime,
  input  wire [2:0] stateVector,
  input  wire [9:0] sensorData,
  input  wire [7:0] deviceData,
  input  wire       deviceDataSel,
  input  wire [9:0] configErrorCode,
  input  wire [2:0] crcValue,
  input  wire       parityValue,
  output reg        txBit,
  output reg        txActive,
  output reg        bitStrobe,
  output wire       frameBusy,
  output reg        frameDone,
  output wire       fullRange,
  output wire       configError,
  output reg  [4:0] frameLength
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SEND = 2'h1;
  localparam ST_STOP = 2'h2;

  reg  [1:0]  state_q;
  reg  [17:0] shift_q;
  reg  [4:0]  left_q;
  reg  [17:0] frame_d;
  reg  [4:0]  len_d;
  reg  [9:0]  dataField;
  reg         noSensor;
  wire        bitTick;

  // Range and configuration error depend only on static configuration.
  assign fullRange   = !state_vector_disable && !autozero_enable;
  assign configError = phase2Mode0 && state_vector_disable;
  assign frameBusy   = (state_q != ST_IDLE);

  sdfb_bit_timer #(.DIV(BIT_DIV)) uTimer
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .run      (frameBusy),
    .bitTick  (bitTick)
  );

  // Assemble the frame LSB first; index 0 leaves the line first.
  always @*
  begin
    frame_d  = 18'h00000;
    len_d    = 5'h00;
    noSensor = configError && runTime;
    // Byte data is left aligned in the wide field; width applies to both.
    if (noSensor)
      dataField = configErrorCode;
    else if (deviceDataSel)
      dataField = (data_width_select == `SDFB_W10) ?
                  {deviceData, 2'b00} : {2'b00, deviceData};
    else
      dataField = (data_width_select == `SDFB_W10) ?
                  sensorData : {2'b00, sensorData[7:0]};
    // Narrow mode must not let the top bits spill into the parity slot.
    if (data_width_select != `SDFB_W10)
      dataField[9:8] = 2'b00;
    frame_d[1:0] = startBits;
    len_d = `SDFB_START_BITS;
    if (check_type_select == `SDFB_CHK_CRC)
    begin
      frame_d = frame_d | ({15'h0000, crcValue} << len_d);
      len_d = len_d + `SDFB_CRC_BITS;
    end
    if (!state_vector_disable)
    begin
      frame_d = frame_d | ({15'h0000, (noSensor ? `SDFB_SV_ERROR :
                stateVector)} << len_d);
      len_d = len_d + `SDFB_SV_BITS;
    end
    frame_d = frame_d | ({8'h00, dataField} << len_d);
    if (data_width_select == `SDFB_W10)
      len_d = len_d + `SDFB_D10_BITS;
    else
      len_d = len_d + `SDFB_D8_BITS;
    if (check_type_select == `SDFB_CHK_PAR)
    begin
      frame_d = frame_d | ({17'h00000, parityValue} << len_d);
      len_d = len_d + `SDFB_PAR_BITS;
    end
  end

  // Frame sequencer: load, shift one bit per tick, then one idle bit.
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q     <= ST_IDLE;
      shift_q     <= 18'h00000;
      left_q      <= 5'h00;
      txBit       <= `SDFB_IDLE_LEVEL;
      txActive    <= 1'b0;
      bitStrobe   <= 1'b0;
      frameDone   <= 1'b0;
      frameLength <= 5'h00;
    end
    else
    begin
      bitStrobe <= 1'b0;
      frameDone <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          txActive <= 1'b0;
          txBit    <= `SDFB_IDLE_LEVEL;
          // Configuration is sampled here and held for the whole frame.
          if (frameStart)
          begin
            state_q     <= ST_SEND;
            txActive    <= 1'b1;
            txBit       <= frame_d[0];
            shift_q     <= frame_d >> 1;
            left_q      <= len_d;
            frameLength <= len_d;
            bitStrobe   <= 1'b1;
          end
        end
        ST_SEND:
          if (bitTick)
          begin
            if (left_q == 5'h01)
            begin
              state_q  <= ST_STOP;
              left_q   <= `SDFB_STOP_BITS;
              txActive <= 1'b0;
              txBit    <= `SDFB_IDLE_LEVEL;
            end
            else
            begin
              left_q    <= left_q - 5'h01;
              txBit     <= shift_q[0];
              shift_q   <= shift_q >> 1;
              bitStrobe <= 1'b1;
            end
          end
        ST_STOP:
          // A full idle bit period passes before the next frame may start.
          if (bitTick)
          begin
            state_q   <= ST_IDLE;
            frameDone <= 1'b1;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** sdfb_defines.vh ***
// Operation
// - Every frame opens with two start bits whose values follow the line coding mode select.
// - After the last frame bit the line is held idle for one bit period as a stop bit.
// - Check type select 0 picks a three bit CRC field and 1 picks one parity bit.
// - CRC follows the start bits directly while parity is the last frame bit.
// - The state vector is sent unless state vector disable is set, then it is left out.
// - Data width select 0 sends ten bit data with byte data left aligned, 1 sends eight bits.
// - The chosen data width applies to both device information and sensor data.
// - Full range is used only when state vector disable and autozero enable are both 0.
// - Phase 2 mode 0 with the state vector disabled sends an error code and no sensor data; the code does so only while runTime is also set.
// - Full range eight bit samples are two's complement from 0x7f through 0x00 to 0x80.
// - The enabled state vector is three bits wide and travels with the data field.
`ifndef SDFB_DEFINES_VH
`define SDFB_DEFINES_VH
`define SDFB_START_BITS 5'h02
`define SDFB_CRC_BITS   5'h03
`define SDFB_PAR_BITS   5'h01
`define SDFB_SV_BITS    5'h03
`define SDFB_D10_BITS   5'h0a
`define SDFB_D8_BITS    5'h08
`define SDFB_STOP_BITS  5'h01
`define SDFB_CHK_CRC    1'b0
`define SDFB_CHK_PAR    1'b1
`define SDFB_W10        1'b0
`define SDFB_SV_ERROR   3'h6
`define SDFB_IDLE_LEVEL 1'b0
`endif

// *** sdfb_bit_timer.v ***
`timescale 1ns/10ps
`default_nettype none
// Divides the core clock down to a one-cycle bit enable pulse.
module sdfb_bit_timer
#(
  parameter DIV = 100
)
(
  input  wire core_clk,
  input  wire rst_b,
  input  wire run,
  output reg  bitTick
);
  reg [15:0] cnt_q;

  // Counter restarts at one when idle. The tick is registered, so starting
  // at one lets the first tick land one full bit period after the load edge.
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q   <= 16'h0000;
      bitTick <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q   <= 16'h0001;
      bitTick <= 1'b0;
    end
    else if (cnt_q >= DIV[15:0] - 16'h0001)
    begin
      cnt_q   <= 16'h0000;
      bitTick <= 1'b1;
    end
    else
    begin
      cnt_q   <= cnt_q + 16'h0001;
      bitTick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** sdfb_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
// Checks frame timing and the range and error flags at the ports.
module sdfb_monitor
#(parameter BIT_DIV = 4)
(
  input wire logic core_clk, rst_b, frameStart, state_vector_disable,
  input wire logic autozero_enable, phase2Mode0, txBit, txActive,
  input wire logic bitStrobe, frameBusy, frameDone, fullRange, configError
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take; frameStart && !frameBusy; endsequence
  property p_take; s_take |=> txActive && bitStrobe; endproperty
  a_take: assert property (p_take) else $error("no start");
  property p_hold; bitStrobe |=> !bitStrobe [*3]; endproperty
  a_hold: assert property (p_hold) else $error("short bit");
  property p_idle; !txActive |-> !txBit; endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  property p_stop; $fell(txActive) |-> ##[3:5] frameDone; endproperty
  a_stop: assert property (p_stop) else $error("stop bit");
  property p_act; txActive |-> frameBusy; endproperty
  a_act: assert property (p_act) else $error("not busy");
  property p_done; frameDone |=> !frameDone && !txActive; endproperty
  a_done: assert property (p_done) else $error("done");
  property p_full;
    fullRange == (!state_vector_disable && !autozero_enable);
  endproperty
  a_full: assert property (p_full) else $error("range");
  property p_cfg; configError == (phase2Mode0 && state_vector_disable);
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg error");
endmodule
bind sdfb_frame_builder sdfb_monitor #(.BIT_DIV(BIT_DIV)) mon (.*);
`default_nettype wire

// *** sdfb_decoder_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sdfb_decoder_model
(
  input wire logic        core_clk, txBit, txActive, bitStrobe,
  output var logic [17:0] rxBits,
  output var logic [4:0]  rxCnt
);
  logic actQ = 1'b0;
  // The first strobe of a frame restarts the count, so no reset is needed.
  always @(posedge core_clk)
  begin
    actQ <= txActive;
    if (bitStrobe && txActive)
    begin
      if (!actQ)
        rxBits <= {17'h0, txBit};
      else
        rxBits[rxCnt] <= txBit;
      rxCnt <= actQ ? rxCnt + 5'h01 : 5'h01;
    end
  end
endmodule
`default_nettype wire

// *** sdfb_frame_builder_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module sdfb_frame_builder_tb;
  logic core_clk = 1'b0, rst_b = 1'b0, frameStart = 1'b0;
  logic check_type_select = 1'b0, state_vector_disable = 1'b0;
  logic data_width_select = 1'b0, autozero_enable = 1'b0;
  logic deviceDataSel = 1'b0, phase2Mode0 = 1'b0, runTime = 1'b0;
  logic parityValue = 1'b1;
  logic [1:0] startBits = 2'h2;
  logic [2:0] stateVector = 3'h3, crcValue = 3'h5;
  logic [9:0] sensorData = 10'h37f, configErrorCode = 10'h2a5;
  logic [7:0] deviceData = 8'h96;
  logic txBit, txActive, bitStrobe, frameBusy, frameDone;
  logic fullRange, configError;
  logic [4:0] frameLength, rxCnt;
  logic [17:0] rxBits;
  int error_cnt = 0, checks = 0;
  always #5 core_clk = ~core_clk;
  sdfb_frame_builder #(.BIT_DIV(4)) dut
  (
    .core_clk             (core_clk),
    .rst_b                (rst_b),
    .frameStart           (frameStart),
    .startBits            (startBits),
    .check_type_select    (check_type_select),
    .state_vector_disable (state_vector_disable),
    .data_width_select    (data_width_select),
    .autozero_enable      (autozero_enable),
    .phase2Mode0          (phase2Mode0),
    .runTime              (runTime),
    .stateVector          (stateVector),
    .sensorData           (sensorData),
    .deviceData           (deviceData),
    .deviceDataSel        (deviceDataSel),
    .configErrorCode      (configErrorCode),
    .crcValue             (crcValue),
    .parityValue          (parityValue),
    .txBit                (txBit),
    .txActive             (txActive),
    .bitStrobe            (bitStrobe),
    .frameBusy            (frameBusy),
    .frameDone            (frameDone),
    .fullRange            (fullRange),
    .configError          (configError),
    .frameLength          (frameLength)
  );
  sdfb_decoder_model peer
  (
    .core_clk  (core_clk),
    .txBit     (txBit),
    .txActive  (txActive),
    .bitStrobe (bitStrobe),
    .rxBits    (rxBits),
    .rxCnt     (rxCnt)
  );
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Sends one frame; the start stays up one extra edge to be refused.
  task automatic run(input logic [2:0] c, input logic ds, er);
    logic [31:0] b;
    logic [9:0] d;
    int n;
    int k;
    @(posedge core_clk);
    {check_type_select, state_vector_disable, data_width_select} <= c;
    autozero_enable <= c[0];
    deviceDataSel <= ds;
    phase2Mode0 <= er;
    runTime <= er;
    frameStart <= 1'b1;
    // Device bytes are left aligned only in the ten bit field.
    d = er ? configErrorCode : ds ? (c[0] ? {2'h0, deviceData} :
        {deviceData, 2'h0}) : sensorData;
    d = c[0] ? {2'h0, d[7:0]} : d;
    b = {30'h0, startBits};
    n = c[2] ? 2 : 5;
    if (!c[2]) b |= {29'h0, crcValue} << 2;
    if (!c[1]) b |= {29'h0, stateVector} << n;
    n += c[1] ? 0 : 3;
    b |= {22'h0, d} << n;
    n += c[0] ? 8 : 10;
    if (c[2]) b |= {31'h0, parityValue} << n;
    n += c[2] ? 1 : 0;
    repeat (2) @(posedge core_clk);
    frameStart <= 1'b0;
    k = 0;
    while (frameDone !== 1'b1 && k < 200)
    begin
      @(negedge core_clk);
      k++;
    end
    chk({31'h0, frameDone}, 32'h1);
    chk({27'h0, rxCnt}, n);
    chk({27'h0, frameLength}, n);
    chk({14'h0, rxBits}, {14'h0, b[17:0]});
    chk({31'h0, fullRange}, {31'h0, !(c[1] | c[0])});
    chk({31'h0, configError}, {31'h0, er});
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
      run(i[2:0], 1'b0, 1'b0);
    run(3'h0, 1'b1, 1'b0);
    run(3'h1, 1'b1, 1'b0);
    run(3'h2, 1'b0, 1'b1);
    run(3'h3, 1'b0, 1'b1);
    stop_test;
  end
  initial
  begin
    #50000;
    error_cnt++;
    stop_test;
  end
endmodule
`default_nettype wire
